/* File: logic/awt_timer.sv */
// Overview of operation
// - Clock select bit picks RC or bus
// - Clock select frozen while or when enabling
// - Pulse mode: high pulse, half minimum period
// - Clock mode: square wave, twice period
// - Pin active only with external and feature enable
// - Feature enable starts timer, clear stops it
// - Interrupt enable gates flag onto request
// - Flag sets at every elapsed period
// - Flag clears by writing one only
// - Six-bit signed trim adjusts RC period
// - Rate writes ignored while enabled
// - RC period: 2*(rate+1)*2 RC periods
// - Bus period: 2*(rate+1) bus cycles
// - RC start delayed by gate release
// - Rate step 0.2 ms at 20 kHz
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`include "awt_defs.svh"

module awt_timer #(
  parameter int ACLK_CYC  = `AWT_ACLK_CYC,  // mclk cycles per RC period
  parameter int TRIM_STEP = `AWT_TRIM_STEP  // mclk cycles per trim step
) (
  input  wire logic               mclk,               // 125 MHz clock
  input  wire logic               rst,                // Async reset
  input  wire logic               ce,                 // Clock enable
  input  wire awt_pkg::awt_req_s  bus_req,            // Register access
  output logic [7:0]              rd_data,            // Read data
  output logic                    irq,                // Interrupt level
  output logic                    timer_waveform_pin  // External wave
);

  awt_pkg::awt_ctl_s   ctl_r;
  awt_pkg::awt_state_e state_r;
  awt_pkg::awt_state_e state_nxt;
  logic                flag_r;
  logic [5:0]          trim_r;
  logic [15:0]         rate_r;
  logic                mask_r;
  logic [7:0]          rd_data_r;
  logic                irq_r;
  logic                pin_r;
  logic [15:0]         acnt_r;
  logic [15:0]         aclk_lim;
  logic                aclk_tick;
  logic                ahalf_r;
  logic [1:0]          gate_r;
  logic [16:0]         cnt_r;
  logic [16:0]         lim;
  logic                unit;
  logic                to_evt;
  logic                pulse_r;
  logic                tgl_r;
  logic                pin_en;
  logic [7:0]          rd_val;
  logic                wr_ctl;
  logic                wr_stat;
  logic                wr_rate;

  // Address decode
  assign wr_ctl  = bus_req.wr && (bus_req.addr == `AWT_OFF_CTL);
  assign wr_stat = bus_req.wr && (bus_req.addr == `AWT_OFF_STAT);
  assign wr_rate = bus_req.wr && ((bus_req.addr == `AWT_OFF_RATE_HI) ||
                                  (bus_req.addr == `AWT_OFF_RATE_LO));

  // Control bits; clock source only moves while idle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctl_r <= '0;
    end else if (ce && wr_ctl) begin
      ctl_r.fe       <= bus_req.wdata[`AWT_B_FE];
      ctl_r.ie       <= bus_req.wdata[`AWT_B_IE];
      ctl_r.ext_en   <= bus_req.wdata[`AWT_B_EXTEN];
      ctl_r.wave_sel <= bus_req.wdata[`AWT_B_WAVE];
      if (!ctl_r.fe && !bus_req.wdata[`AWT_B_FE]) begin
        ctl_r.clk_sel <= bus_req.wdata[`AWT_B_CLKSEL];
      end
    end
  end

  // Timeout flag; a timeout in the clearing cycle wins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flag_r <= 1'b0;
    end else if (ce) begin
      if (to_evt) begin
        flag_r <= 1'b1;
      end else if ((wr_ctl || wr_stat) && bus_req.wdata[`AWT_B_FLAG]) begin
        flag_r <= 1'b0;
      end
    end
  end

  // RC trim, written any time
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      trim_r <= `AWT_RST_TRIM;
    end else if (ce && bus_req.wr && bus_req.addr == `AWT_OFF_TRIM) begin
      trim_r <= bus_req.wdata[7:`AWT_TRIM_LSB];
    end
  end

  // Rate bytes; locked while enabled so a running period stays coherent
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rate_r <= `AWT_RST_RATE;
    end else if (ce && wr_rate && !ctl_r.fe) begin
      if (bus_req.addr == `AWT_OFF_RATE_HI) begin
        rate_r[15:8] <= bus_req.wdata;
      end else begin
        rate_r[7:0] <= bus_req.wdata;
      end
    end
  end

  // Interrupt mask
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mask_r <= `AWT_RST_MASK;
    end else if (ce && bus_req.wr && bus_req.addr == `AWT_OFF_MASK) begin
      mask_r <= bus_req.wdata[0];
    end
  end

  // Read mux; unmapped and reserved bits read zero
  always_comb begin
    rd_val = 8'h00;
    unique case (bus_req.addr)
      `AWT_OFF_CTL:     rd_val = {ctl_r.clk_sel, 2'h0, ctl_r.wave_sel,
                                  ctl_r.ext_en, ctl_r.fe, ctl_r.ie, flag_r};
      `AWT_OFF_TRIM:    rd_val = {trim_r, 2'h0};
      `AWT_OFF_RATE_HI: rd_val = rate_r[15:8];
      `AWT_OFF_RATE_LO: rd_val = rate_r[7:0];
      `AWT_OFF_STAT:    rd_val = {7'h00, flag_r};
      `AWT_OFF_MASK:    rd_val = {7'h00, mask_r};
      default:          rd_val = 8'h00;
    endcase
  end

  // Read data stands for one cycle only
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_data_r <= 8'h00;
    end else if (ce) begin
      rd_data_r <= bus_req.rd ? rd_val : 8'h00;
    end
  end

  // RC period from trim; sign bit lengthens, lower bits shorten; clamped
  always_comb begin
    int p;
    p = ACLK_CYC - int'($signed(trim_r)) * TRIM_STEP;
    if (p < 2) begin
      p = 2;
    end
    aclk_lim = 16'(p - 1);
  end

  assign aclk_tick = (acnt_r >= aclk_lim);

  // Free-running model of the RC clock as a tick
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acnt_r <= 16'h0000;
    end else if (ce) begin
      acnt_r <= aclk_tick ? 16'h0000 : 16'(acnt_r + 16'h0001);
    end
  end

  // Half-unit phase: one count unit is two RC periods
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ahalf_r <= 1'b0;
    end else if (ce) begin
      if (state_r != awt_pkg::ST_RUN) begin
        ahalf_r <= 1'b0;
      end else if (aclk_tick) begin
        ahalf_r <= !ahalf_r;
      end
    end
  end

  // Count unit: bus cycle, or every second RC period
  assign unit = ctl_r.clk_sel ? 1'b1 : (aclk_tick && ahalf_r);

  // Start sequence; RC source waits for the gate release
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      awt_pkg::ST_IDLE: begin
        if (ctl_r.fe) begin
          state_nxt = ctl_r.clk_sel ? awt_pkg::ST_RUN : awt_pkg::ST_GATE;
        end
      end
      awt_pkg::ST_GATE: begin
        if (!ctl_r.fe) begin
          state_nxt = awt_pkg::ST_IDLE;
        end else if (aclk_tick && gate_r == 2'(`AWT_GATE_ACLK - 1)) begin
          state_nxt = awt_pkg::ST_RUN;
        end
      end
      awt_pkg::ST_RUN: begin
        if (!ctl_r.fe) begin
          state_nxt = awt_pkg::ST_IDLE;
        end
      end
      default: state_nxt = awt_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= awt_pkg::ST_IDLE;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // Gate release counter in RC periods
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gate_r <= 2'h0;
    end else if (ce) begin
      if (state_r != awt_pkg::ST_GATE) begin
        gate_r <= 2'h0;
      end else if (aclk_tick) begin
        gate_r <= 2'(gate_r + 2'h1);
      end
    end
  end

  // Period is 2*(rate+1) units, so last count is 2*rate+1
  assign lim    = {rate_r, 1'b1};
  // Enable gates timeouts so none lands in the cycle the timer stops
  assign to_evt = (state_r == awt_pkg::ST_RUN) && ctl_r.fe && unit && (cnt_r == lim);

  // Period counter reloads by itself
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_r <= 17'h00000;
    end else if (ce) begin
      if (state_r != awt_pkg::ST_RUN) begin
        cnt_r <= 17'h00000;
      end else if (unit) begin
        cnt_r <= (cnt_r == lim) ? 17'h00000 : 17'(cnt_r + 17'h00001);
      end
    end
  end

  // Pulse lasts one unit, half the minimum period
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pulse_r <= 1'b0;
    end else if (ce) begin
      if (to_evt) begin
        pulse_r <= 1'b1;
      end else if (unit || state_r != awt_pkg::ST_RUN) begin
        pulse_r <= 1'b0;
      end
    end
  end

  // Toggle per timeout gives a clock of twice the period
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tgl_r <= 1'b0;
    end else if (ce) begin
      if (!ctl_r.fe) begin
        tgl_r <= 1'b0;
      end else if (to_evt) begin
        tgl_r <= !tgl_r;
      end
    end
  end

  // Pin and interrupt come straight from flops
  assign pin_en = ctl_r.ext_en && ctl_r.fe;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_r <= 1'b0;
    end else if (ce) begin
      pin_r <= pin_en && (ctl_r.wave_sel ? tgl_r : pulse_r);
    end
  end

  // Level request while flag, enable and mask all set
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else if (ce) begin
      irq_r <= flag_r && ctl_r.ie && mask_r;
    end
  end

  assign rd_data            = rd_data_r;
  assign irq                = irq_r;
  assign timer_waveform_pin = pin_r;

  // Checking helpers: bus-mode gap between timeouts
  logic [17:0] gap_r;
  logic        seen_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gap_r  <= 18'h00000;
      seen_r <= 1'b0;
    end else if (ce) begin
      if (!ctl_r.fe) begin
        seen_r <= 1'b0;
        gap_r  <= 18'h00000;
      end else if (to_evt) begin
        seen_r <= 1'b1;
        gap_r  <= 18'h00000;
      end else begin
        gap_r <= 18'(gap_r + 18'h00001);
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence ctl_wr_s;
    ce && wr_ctl;
  endsequence

  sequence wave_to_s;
    ce && to_evt && pin_en && ctl_r.wave_sel
      ##1 ce && pin_en && ctl_r.wave_sel;
  endsequence

  sequence pulse_to_s;
    ce && to_evt && pin_en && !ctl_r.wave_sel
      ##1 ce && pin_en && !ctl_r.wave_sel;
  endsequence

  clk_sel_hold_a:
    assert property (ctl_wr_s ##0 (ctl_r.fe || bus_req.wdata[`AWT_B_FE])
                     |=> $stable(ctl_r.clk_sel))
    else $error("clock select changed while enabled");

  rate_lock_a:
    assert property (ce && wr_rate && ctl_r.fe |=> $stable(rate_r))
    else $error("rate changed while enabled");

  flag_set_a:
    assert property (ce && to_evt |=> flag_r)
    else $error("timeout did not set flag");

  flag_keep_a:
    assert property (ctl_wr_s ##0 (flag_r && !bus_req.wdata[`AWT_B_FLAG])
                     |=> flag_r)
    else $error("writing zero cleared flag");

  irq_gate_a:
    assert property (irq |-> $past(ctl_r.ie) && $past(flag_r))
    else $error("request without enabled flag");

  irq_raise_a:
    assert property (ce && flag_r && ctl_r.ie && mask_r |=> irq)
    else $error("enabled flag gave no request");

  pin_off_a:
    assert property (ce && !pin_en |=> !timer_waveform_pin)
    else $error("waveform on pin while disabled");

  fe_quiet_a:
    assert property (ce && !ctl_r.fe && !flag_r |=> !flag_r)
    else $error("timeout while disabled");

  bus_period_a:
    assert property (ce && to_evt && seen_r && ctl_r.clk_sel
                     |-> gap_r == {1'b0, lim})
    else $error("bus-clock period wrong");

  wave_toggle_a:
    assert property (wave_to_s |=> $changed(timer_waveform_pin))
    else $error("clock wave did not toggle");

  pulse_high_a:
    assert property (pulse_to_s |=> timer_waveform_pin)
    else $error("pulse missing after timeout");

endmodule : awt_timer

/* File: shared/awt_defs.svh */
`ifndef AWT_DEFS_SVH
`define AWT_DEFS_SVH

// Register offsets
`define AWT_OFF_CTL     8'h12
`define AWT_OFF_TRIM    8'h13
`define AWT_OFF_RATE_HI 8'h14
`define AWT_OFF_RATE_LO 8'h15
`define AWT_OFF_STAT    8'h16
`define AWT_OFF_MASK    8'h17

// Control register fields
`define AWT_B_CLKSEL 7
`define AWT_B_WAVE   4
`define AWT_B_EXTEN  3
`define AWT_B_FE     2
`define AWT_B_IE     1
`define AWT_B_FLAG   0

// Trim field low bit
`define AWT_TRIM_LSB 2

// Reset values
`define AWT_RST_TRIM 6'h00
`define AWT_RST_RATE 16'h0000
`define AWT_RST_MASK 1'h1

// Timing: RC clock nominal rate and mclk rate
`define AWT_MCLK_HZ   125000000
`define AWT_ACLK_HZ   20000
`define AWT_ACLK_CYC  (`AWT_MCLK_HZ / `AWT_ACLK_HZ)
`define AWT_TRIM_STEP 32
`define AWT_GATE_ACLK 2

`endif

/* File: shared/awt_pkg.sv */
package awt_pkg;

  // One register access from software
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } awt_req_s;

  // Stored control bits (flag kept apart)
  typedef struct packed {
    logic clk_sel;
    logic wave_sel;
    logic ext_en;
    logic fe;
    logic ie;
  } awt_ctl_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_GATE,
    ST_RUN
  } awt_state_e;

endpackage : awt_pkg

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`include "awt_defs.svh"

module testbench;
  localparam logic [7:0] CTL = `AWT_OFF_CTL;
  localparam logic [7:0] TRM = `AWT_OFF_TRIM;
  localparam logic [7:0] RHI = `AWT_OFF_RATE_HI;
  localparam logic [7:0] RLO = `AWT_OFF_RATE_LO;
  localparam logic [7:0] STA = `AWT_OFF_STAT;
  localparam logic [7:0] MSK = `AWT_OFF_MASK;
  localparam int         RC  = 4;  // Short RC period keeps RC runs brief

  logic              mclk;         // Bus clock
  logic              rst;          // Async reset
  logic              ce;           // Clock enable
  awt_pkg::awt_req_s req;          // Register access
  logic [7:0]        rd_data;      // Read data
  logic              irq;          // Interrupt level
  logic              pin;          // Timer waveform
  int                failures;
  int                checks_done;
  logic [15:0]       rates [3] = '{16'h0000, 16'h0002, 16'h0100};
  logic [7:0]        trims [3] = '{8'h00, 8'h04, 8'hFC};
  int                rcs   [3] = '{RC, RC - 1, RC + 1};

  awt_timer #(.ACLK_CYC(RC), .TRIM_STEP(1)) u_awt_timer (
    .mclk               (mclk),
    .rst                (rst),
    .ce                 (ce),
    .bus_req            (req),
    .rd_data            (rd_data),
    .irq                (irq),
    .timer_waveform_pin (pin)
  );

  // Free-running 125 MHz clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  // Tasks enter and leave on a rising edge; the gap cycle avoids double drives
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req <= '0;
    @(posedge mclk);
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req <= '0;
    #1;
    chk(nm, {24'h0, exp}, {24'h0, rd_data});
    @(posedge mclk);
  endtask : rd

  // Sample pin or irq once edge updates have landed
  task automatic sig(input string nm, input logic exp, input logic sel_pin);
    #1;
    chk(nm, {31'h0, exp}, {31'h0, sel_pin ? pin : irq});
    @(posedge mclk);
  endtask : sig

  // Counts cycles the pin stays at v, bounded against a hang
  task automatic run(input logic v, output int n);
    n = 0;
    while (n < 3000) begin
      #1;
      if (pin !== v) break;
      @(posedge mclk);
      n++;
    end
    if (n >= 3000) begin
      failures++;
      report_and_stop();
    end
  endtask : run

  task automatic measure(input int per, input int hi, input string nm);
    int h;
    int l;
    run(1'b1, h);
    run(1'b0, l);
    run(1'b1, h);
    run(1'b0, l);
    chk(nm, hi, h);
    chk(nm, per, h + l);
    @(posedge mclk);  // Realign so the next access starts on an edge
  endtask : measure

  // Main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    req = '0;
    failures = 0;
    checks_done = 0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(CTL, 8'h00, "control reset");
    rd(TRM, 8'h00, "trim reset");
    rd(RHI, 8'h00, "rate high reset");
    rd(RLO, 8'h00, "rate low reset");
    rd(STA, 8'h00, "status reset");
    rd(MSK, 8'h01, "mask reset");
    rd(8'h30, 8'h00, "unmapped");
    wr(TRM, 8'hFF);
    rd(TRM, 8'hFC, "trim field");
    wr(RHI, 8'hA5);
    rd(RHI, 8'hA5, "rate high");
    ce <= 1'b0;
    wr(RHI, 8'h3C);
    ce <= 1'b1;
    rd(RHI, 8'hA5, "frozen write");
    wr(TRM, 8'h00);
    $display("test registers done");
    // Bus clock periods over a table of rates
    wr(CTL, 8'h80);
    rd(CTL, 8'h80, "clock select");
    for (int i = 0; i < 3; i++) begin
      wr(RHI, rates[i][15:8]);
      wr(RLO, rates[i][7:0]);
      wr(CTL, 8'h8C);
      measure(2 * (int'(rates[i]) + 1), 1, "bus pulse");
      wr(CTL, 8'h80);
    end
    wr(STA, 8'h01);
    $display("test bus periods done");
    // Configuration locked while running, flag and request
    wr(RHI, 8'h00);
    wr(RLO, 8'h02);
    wr(CTL, 8'h8E);
    measure(6, 1, "running pulse");
    wr(RLO, 8'h09);
    rd(RLO, 8'h02, "rate locked");
    wr(CTL, 8'h0E);
    rd(CTL, 8'h8F, "select locked");
    sig("irq raised", 1'b1, 1'b0);
    wr(CTL, 8'h82);
    wr(STA, 8'h00);
    rd(STA, 8'h01, "flag kept");
    sig("pin stopped", 1'b0, 1'b1);
    wr(MSK, 8'h00);
    sig("irq masked", 1'b0, 1'b0);
    wr(MSK, 8'h01);
    sig("irq unmasked", 1'b1, 1'b0);
    wr(STA, 8'h01);
    rd(STA, 8'h00, "flag cleared");
    sig("irq cleared", 1'b0, 1'b0);
    $display("test flag done");
    // No request without enable, no waveform without external enable
    wr(CTL, 8'h84);
    repeat (20) sig("pin silent", 1'b0, 1'b1);
    rd(STA, 8'h01, "flag set");
    sig("irq off", 1'b0, 1'b0);
    wr(CTL, 8'h80);
    wr(STA, 8'h01);
    wr(CTL, 8'h04);
    rd(CTL, 8'h84, "select held");
    wr(CTL, 8'h80);
    wr(CTL, 8'h9C);
    measure(12, 6, "square clock");
    wr(CTL, 8'h98);
    sig("pin idle", 1'b0, 1'b1);
    $display("test waveforms done");
    // RC source: four RC periods per period at rate zero, scaled by trim
    wr(CTL, 8'h00);
    wr(RLO, 8'h00);
    wr(STA, 8'h01);
    for (int i = 0; i < 3; i++) begin
      wr(TRM, trims[i]);
      wr(CTL, 8'h0C);
      measure(4 * rcs[i], 2 * rcs[i], "rc pulse");
      wr(CTL, 8'h00);
    end
    $display("test rc source done");
    report_and_stop();
  end
endmodule : testbench
